// ===== src/mts_map.svh
// Register offsets, field positions and reset values of the transmit
// status and interrupt mask block.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MTS_ADDR_TSR 8'h14
`define MTS_ADDR_ISR 8'h24
`define MTS_ADDR_IER 8'h28
`define MTS_ADDR_IDR 8'h2c
`define MTS_ADDR_IMR 8'h30

// ****************************************************************
// Transmit status fields
// ****************************************************************
`define MTS_TSR_W 7
`define MTS_TSR_USED_BIT 0
`define MTS_TSR_COLL_BIT 1
`define MTS_TSR_RETRY_BIT 2
`define MTS_TSR_ACTIVE_BIT 3
`define MTS_TSR_EXH_BIT 4
`define MTS_TSR_DONE_BIT 5
`define MTS_TSR_URUN_BIT 6
`define MTS_TSR_STICKY_MASK 7'h77
`define MTS_TSR_RESET 7'h00

// ****************************************************************
// Interrupt source fields
// ****************************************************************
`define MTS_IRQ_W 14
`define MTS_IRQ_MGMT_BIT 0
`define MTS_IRQ_RXDONE_BIT 1
`define MTS_IRQ_RXUSED_BIT 2
`define MTS_IRQ_TXUSED_BIT 3
`define MTS_IRQ_TXURUN_BIT 4
`define MTS_IRQ_RETRY_BIT 5
`define MTS_IRQ_TXEXH_BIT 6
`define MTS_IRQ_TXDONE_BIT 7
`define MTS_IRQ_RXOVR_BIT 10
`define MTS_IRQ_BUSERR_BIT 11
`define MTS_IRQ_PAUSERX_BIT 12
`define MTS_IRQ_PAUSEZERO_BIT 13
`define MTS_IRQ_VALID_MASK 14'h3cff
`define MTS_ISR_RESET 14'h0000
`define MTS_IMR_RESET 14'h3cff

// ****************************************************************
// Bus widths
// ****************************************************************
`define MTS_DATA_W 32
`define MTS_RDATA_RESET 32'h0000_0000

`endif

// ===== src/mts_pkg.sv
// Types shared by the transmit status and interrupt mask block.
// Assumes the constants of mts_map.svh.
`default_nettype none
`include "mts_map.svh"

package mts_pkg;

  // ****************************************************************
  // Event carriers
  // ****************************************************************
  typedef struct packed {
    logic used_bit_read;
    logic collision;
    logic retry_limit;
    logic exhausted;
    logic frame_done;
    logic grant_late;
    logic hresp_error;
    logic used_mid_frame;
  } mts_tx_evt_t;

  typedef struct packed {
    logic mgmt_done;
    logic rx_done;
    logic rx_used_bit;
    logic rx_overrun;
    logic bus_error;
    logic pause_rx;
    logic pause_zero;
  } mts_other_evt_t;

  // ****************************************************************
  // Transmit path controls
  // ****************************************************************
  typedef struct packed {
    logic abort;
    logic fcs_corrupt;
    logic tx_er;
  } mts_tx_ctl_t;

  // ****************************************************************
  // Top-level state
  // ****************************************************************
  typedef struct packed {
    logic [`MTS_IRQ_W-1:0] imr;
    logic [`MTS_DATA_W-1:0] rdata;
    logic err_hold;
    logic corrupt_hold;
    logic abort;
    logic irq;
  } mts_state_t;

endpackage : mts_pkg

`default_nettype wire

// ===== src/mts_sticky_flags.sv
// Bank of sticky flags: hardware sets, write-one clears.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module mts_sticky_flags #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } mts_flag_state_t;

  mts_flag_state_t st_r;
  mts_flag_state_t st_nxt;

  if (W < 1) begin : g_bad_w
    $error("mts_sticky_flags: W must be at least 1");
  end

  // ****************************************************************
  // Per-bit update: the set wins over a clear in the same cycle
  // ****************************************************************
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_comb begin
      st_nxt.flags[b] = i_set[b] | (st_r.flags[b] & ~i_clr[b]);
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      st_r.flags <= RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_flags = st_r.flags;

endmodule // mts_sticky_flags

`default_nettype wire

// ===== src/mts_tx_status.sv
// Transmit status and interrupt mask block of the Ethernet MAC.
// Assumes the transmit DMA and transmit path run on I_CLK_SYS and present
// their events as one-cycle pulses; the register port never waits.
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"

module mts_tx_status #(
  parameter int ADDR_W = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [`MTS_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [`MTS_DATA_W-1:0] O_RDATA,
  input wire mts_pkg::mts_tx_evt_t I_TX_EVT,
  input wire mts_pkg::mts_other_evt_t I_OTHER_EVT,
  input wire logic I_TX_ACTIVE,
  output mts_pkg::mts_tx_ctl_t O_TX_CTL,
  output logic O_IRQ
);

  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
    $error("mts_tx_status: ADDR_W must be 6 to 8");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  mts_pkg::mts_state_t st_r;
  mts_pkg::mts_state_t st_nxt;

  logic [7:0] addr_full;
  logic wr_tsr;
  logic wr_isr;
  logic wr_ier;
  logic wr_idr;
  logic underrun_evt;
  logic exhausted_evt;

  logic [`MTS_TSR_W-1:0] tsr_set;
  logic [`MTS_TSR_W-1:0] tsr_clr;
  logic [`MTS_TSR_W-1:0] tsr_flags;
  logic [`MTS_TSR_W-1:0] tsr_view;

  logic [`MTS_IRQ_W-1:0] isr_set;
  logic [`MTS_IRQ_W-1:0] isr_clr;
  logic [`MTS_IRQ_W-1:0] isr_flags;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    addr_full = 8'h00;
    addr_full[ADDR_W-1:0] = I_ADDR;
  end

  assign wr_tsr = I_WR && (addr_full == `MTS_ADDR_TSR);
  assign wr_isr = I_WR && (addr_full == `MTS_ADDR_ISR);
  assign wr_ier = I_WR && (addr_full == `MTS_ADDR_IER);
  assign wr_idr = I_WR && (addr_full == `MTS_ADDR_IDR);

  // ****************************************************************
  // Transmit events
  // ****************************************************************
  assign underrun_evt = I_TX_EVT.grant_late
                      | I_TX_EVT.hresp_error
                      | I_TX_EVT.used_mid_frame;

  // Exhaustion only matters while a frame is on the wire
  assign exhausted_evt = I_TX_EVT.exhausted & I_TX_ACTIVE;

  always_comb begin
    tsr_set = `MTS_TSR_RESET;
    tsr_set[`MTS_TSR_USED_BIT] = I_TX_EVT.used_bit_read;
    tsr_set[`MTS_TSR_COLL_BIT] = I_TX_EVT.collision;
    tsr_set[`MTS_TSR_RETRY_BIT] = I_TX_EVT.retry_limit;
    tsr_set[`MTS_TSR_EXH_BIT] = exhausted_evt;
    tsr_set[`MTS_TSR_DONE_BIT] = I_TX_EVT.frame_done;
    tsr_set[`MTS_TSR_URUN_BIT] = underrun_evt;
  end

  // Only a written one clears, and only at a sticky position
  always_comb begin
    tsr_clr = `MTS_TSR_RESET;
    if (wr_tsr) begin
      tsr_clr = I_WDATA[`MTS_TSR_W-1:0] & `MTS_TSR_STICKY_MASK;
    end
  end

  // Write data never reaches the set side of the flags
  mts_sticky_flags #(
    .W(`MTS_TSR_W),
    .RESET_VAL(`MTS_TSR_RESET)
  ) u_tsr_flags (
    .I_CLK_SYS(I_CLK_SYS),
    .I_SYS_RST(I_SYS_RST),
    .i_set(tsr_set),
    .i_clr(tsr_clr),
    .o_flags(tsr_flags)
  );

  // Live activity replaces the unused sticky slot
  always_comb begin
    tsr_view = tsr_flags;
    tsr_view[`MTS_TSR_ACTIVE_BIT] = I_TX_ACTIVE;
  end

  // ****************************************************************
  // Interrupt sources
  // ****************************************************************
  always_comb begin
    isr_set = `MTS_ISR_RESET;
    isr_set[`MTS_IRQ_MGMT_BIT] = I_OTHER_EVT.mgmt_done;
    isr_set[`MTS_IRQ_RXDONE_BIT] = I_OTHER_EVT.rx_done;
    isr_set[`MTS_IRQ_RXUSED_BIT] = I_OTHER_EVT.rx_used_bit;
    isr_set[`MTS_IRQ_TXUSED_BIT] = I_TX_EVT.used_bit_read;
    isr_set[`MTS_IRQ_TXURUN_BIT] = underrun_evt;
    isr_set[`MTS_IRQ_RETRY_BIT] = I_TX_EVT.retry_limit;
    isr_set[`MTS_IRQ_TXEXH_BIT] = exhausted_evt;
    isr_set[`MTS_IRQ_TXDONE_BIT] = I_TX_EVT.frame_done;
    isr_set[`MTS_IRQ_RXOVR_BIT] = I_OTHER_EVT.rx_overrun;
    isr_set[`MTS_IRQ_BUSERR_BIT] = I_OTHER_EVT.bus_error;
    isr_set[`MTS_IRQ_PAUSERX_BIT] = I_OTHER_EVT.pause_rx;
    isr_set[`MTS_IRQ_PAUSEZERO_BIT] = I_OTHER_EVT.pause_zero;
  end

  always_comb begin
    isr_clr = `MTS_ISR_RESET;
    if (wr_isr) begin
      isr_clr = I_WDATA[`MTS_IRQ_W-1:0] & `MTS_IRQ_VALID_MASK;
    end
  end

  mts_sticky_flags #(
    .W(`MTS_IRQ_W),
    .RESET_VAL(`MTS_ISR_RESET)
  ) u_isr_flags (
    .I_CLK_SYS(I_CLK_SYS),
    .I_SYS_RST(I_SYS_RST),
    .i_set(isr_set),
    .i_clr(isr_clr),
    .o_flags(isr_flags)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;

    // Mask: enable writes clear mask bits, disable writes set them
    if (wr_ier) begin
      st_nxt.imr = st_r.imr
                 & ~(I_WDATA[`MTS_IRQ_W-1:0] & `MTS_IRQ_VALID_MASK);
    end else if (wr_idr) begin
      st_nxt.imr = st_r.imr
                 | (I_WDATA[`MTS_IRQ_W-1:0] & `MTS_IRQ_VALID_MASK);
    end

    // Read data stands for exactly one cycle after the strobe
    st_nxt.rdata = `MTS_RDATA_RESET;
    if (I_RD) begin
      unique case (addr_full)
        `MTS_ADDR_TSR: begin
          st_nxt.rdata[`MTS_TSR_W-1:0] = tsr_view;
        end
        `MTS_ADDR_ISR: begin
          st_nxt.rdata[`MTS_IRQ_W-1:0] = isr_flags;
        end
        `MTS_ADDR_IMR: begin
          st_nxt.rdata[`MTS_IRQ_W-1:0] = st_r.imr;
        end
        default: begin
          st_nxt.rdata = `MTS_RDATA_RESET;
        end
      endcase
    end

    // Exhaustion stops the frame and holds tx_er to its end
    st_nxt.abort = exhausted_evt;
    if (exhausted_evt) begin
      st_nxt.err_hold = 1'b1;
    end else if (!I_TX_ACTIVE) begin
      st_nxt.err_hold = 1'b0;
    end

    // Either fault poisons the CRC of the frame in flight
    if (exhausted_evt || (underrun_evt && I_TX_ACTIVE)) begin
      st_nxt.corrupt_hold = 1'b1;
    end else if (!I_TX_ACTIVE) begin
      st_nxt.corrupt_hold = 1'b0;
    end

    st_nxt.irq = |(isr_flags & ~st_r.imr);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      st_r.imr <= `MTS_IMR_RESET;
      st_r.rdata <= `MTS_RDATA_RESET;
      st_r.err_hold <= 1'b0;
      st_r.corrupt_hold <= 1'b0;
      st_r.abort <= 1'b0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_RDATA = st_r.rdata;
  // One driver fills the whole control struct
  always_comb begin
    O_TX_CTL = '0;
    O_TX_CTL.abort = st_r.abort;
    O_TX_CTL.fcs_corrupt = st_r.corrupt_hold;
    O_TX_CTL.tx_er = st_r.err_hold;
  end
  assign O_IRQ = st_r.irq;

endmodule // mts_tx_status

`default_nettype wire

// ===== sim/mts_tx_path_model.sv
// Behavioural transmit path that feeds the transmit-active level.
// Assumes one system clock; an abort from the block ends the frame early.
`timescale 1ns/1ps
`default_nettype none

module mts_tx_path_model #(
  parameter int LEN = 12
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire mts_pkg::mts_tx_ctl_t i_ctl,
  output logic o_active
);
  int cnt_r;

  // Frame runs LEN cycles unless the block aborts it
  always_ff @(posedge i_clk) begin
    if (i_rst || i_ctl.abort) begin
      cnt_r <= 0;
    end else if (i_start) begin
      cnt_r <= LEN;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end
  end

  assign o_active = (cnt_r > 0);
endmodule // mts_tx_path_model
`default_nettype wire

// ===== sim/mts_tx_status_chk.sv
// Port-level checks of the transmit status block.
// Assumes it is bound onto mts_tx_status; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"

module mts_tx_status_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [`MTS_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [`MTS_DATA_W-1:0] O_RDATA,
  input wire mts_pkg::mts_tx_evt_t I_TX_EVT,
  input wire mts_pkg::mts_other_evt_t I_OTHER_EVT,
  input wire logic I_TX_ACTIVE,
  input wire mts_pkg::mts_tx_ctl_t O_TX_CTL,
  input wire logic O_IRQ
);
  logic wrote_r;

  // Remembers that software has written since reset
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      wrote_r <= 1'b0;
    end else if (I_WR) begin
      wrote_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  sequence s_exh;
    I_TX_EVT.exhausted && I_TX_ACTIVE;
  endsequence
  sequence s_urun;
    (I_TX_EVT.grant_late || I_TX_EVT.hresp_error || I_TX_EVT.used_mid_frame)
      && I_TX_ACTIVE;
  endsequence
  sequence s_kill;
    O_TX_CTL.abort && O_TX_CTL.tx_er && O_TX_CTL.fcs_corrupt;
  endsequence

  property p_exh_ctl;
    s_exh |=> s_kill;
  endproperty
  a_exh_ctl: assert property (p_exh_ctl)
    else $error("exhausted frame not stopped");
  property p_abort_cause;
    O_TX_CTL.abort |-> $past(I_TX_EVT.exhausted && I_TX_ACTIVE);
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without cause");
  property p_txer_cause;
    $rose(O_TX_CTL.tx_er) |-> $past(I_TX_EVT.exhausted && I_TX_ACTIVE);
  endproperty
  a_txer_cause: assert property (p_txer_cause)
    else $error("tx_er without cause");
  property p_urun_fcs;
    s_urun |=> O_TX_CTL.fcs_corrupt;
  endproperty
  a_urun_fcs: assert property (p_urun_fcs)
    else $error("underrun frame kept good crc");
  property p_idle_clear;
    !I_TX_ACTIVE |=> !O_TX_CTL.fcs_corrupt && !O_TX_CTL.tx_er;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("error controls outlive frame");
  property p_active_view;
    I_RD && I_ADDR == `MTS_ADDR_TSR |=> O_RDATA[3] == $past(I_TX_ACTIVE);
  endproperty
  a_active_view: assert property (p_active_view)
    else $error("active flag wrong");
  property p_imr_resv;
    I_RD && I_ADDR == `MTS_ADDR_IMR |=> O_RDATA[31:14] == '0
      && O_RDATA[9:8] == 2'h0;
  endproperty
  a_imr_resv: assert property (p_imr_resv)
    else $error("mask reserved bits set");
  property p_irq_masked;
    !wrote_r |-> !O_IRQ;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt while all masked");
endmodule // mts_tx_status_chk
`default_nettype wire

// ===== sim/mts_tx_status_tb_top.sv
// Self-checking bench of the transmit status block.
// Assumes the path model supplies the active level.
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"

module mts_tx_status_tb_top;
  logic clk = 1'b0;
  logic rst, wr_s, rd_s, start, irq, tx_act;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  mts_pkg::mts_tx_evt_t tx_evt;
  mts_pkg::mts_other_evt_t oth_evt;
  mts_pkg::mts_tx_ctl_t tx_ctl;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] tsr_of [8] = '{32'h40, 32'h40, 32'h40, 32'h20, 32'h10,
    32'h04, 32'h02, 32'h01};
  logic [31:0] isr_of [8] = '{32'h10, 32'h10, 32'h10, 32'h80, 32'h40,
    32'h20, 32'h00, 32'h08};

  always #2 clk = ~clk;

  mts_tx_status #(.ADDR_W(8)) DUT (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
    .O_RDATA(rdata), .I_TX_EVT(tx_evt), .I_OTHER_EVT(oth_evt),
    .I_TX_ACTIVE(tx_act), .O_TX_CTL(tx_ctl), .O_IRQ(irq));
  mts_tx_path_model #(.LEN(12)) u_path (.i_clk(clk), .i_rst(rst),
    .i_start(start), .i_ctl(tx_ctl), .o_active(tx_act));

  // ****************************************************************
  // Bus, event, frame, check and end-of-test tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic do_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic do_rd(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk("rdata", rdata & m, e);
  endtask
  task automatic ev(input logic [7:0] t, input logic [6:0] o);
    @(posedge clk);
    tx_evt <= t;
    oth_evt <= o;
    @(posedge clk);
    tx_evt <= '0;
    oth_evt <= '0;
  endtask
  task automatic frame();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst, wr_s, rd_s, start, addr, wdata} = {4'h8, 8'h00, 32'h0};
    tx_evt = '0;
    oth_evt = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    do_rd(`MTS_ADDR_TSR, '1, 32'h0);
    do_rd(`MTS_ADDR_IMR, '1, 32'h3cff);
    do_wr(`MTS_ADDR_IMR, '1);
    do_rd(`MTS_ADDR_IMR, '1, 32'h3cff);
    do_rd(8'h00, '1, 32'h0);
    do_wr(`MTS_ADDR_TSR, 32'h7f);
    do_rd(`MTS_ADDR_TSR, '1, 32'h0);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        frame();
      end
      ev(8'h01 << i, 7'h00);
      if (i == 4) begin
        #1 chk("tx_ctl", {29'h0, tx_ctl}, 32'h7);
      end
      do_rd(`MTS_ADDR_TSR, 32'h77, tsr_of[i]);
      do_rd(`MTS_ADDR_ISR, 32'h3cff, isr_of[i]);
      do_wr(`MTS_ADDR_TSR, 32'h77 & ~tsr_of[i]);
      do_rd(`MTS_ADDR_TSR, 32'h77, tsr_of[i]);
      do_wr(`MTS_ADDR_TSR, tsr_of[i]);
      do_rd(`MTS_ADDR_TSR, 32'h77, 32'h0);
      do_wr(`MTS_ADDR_ISR, 32'h3cff);
    end
    ev(8'h10, 7'h00);
    do_rd(`MTS_ADDR_TSR, 32'h10, 32'h0);
    frame();
    ev(8'h04, 7'h00);
    #1 chk("tx_ctl", {29'h0, tx_ctl}, 32'h2);
    do_rd(`MTS_ADDR_TSR, 32'h08, 32'h08);
    repeat (14) @(posedge clk);
    do_rd(`MTS_ADDR_TSR, 32'h08, 32'h0);
    chk("tx_ctl", {29'h0, tx_ctl}, 32'h0);
    do_wr(`MTS_ADDR_TSR, 32'h77);
    do_wr(`MTS_ADDR_ISR, 32'h3cff);
    ev(8'h08, 7'h00);
    repeat (2) @(posedge clk);
    #1 chk("irq", {31'h0, irq}, 32'h0);
    do_wr(`MTS_ADDR_IER, 32'h80);
    do_rd(`MTS_ADDR_IMR, '1, 32'h3c7f);
    chk("irq", {31'h0, irq}, 32'h1);
    do_wr(`MTS_ADDR_IDR, 32'h80);
    do_rd(`MTS_ADDR_IMR, '1, 32'h3cff);
    chk("irq", {31'h0, irq}, 32'h0);
    ev(8'h00, 7'h7f);
    do_rd(`MTS_ADDR_ISR, '1, 32'h3c87);
    do_wr(`MTS_ADDR_IER, 32'h3cff);
    do_rd(`MTS_ADDR_IMR, '1, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    do_wr(`MTS_ADDR_ISR, 32'h3cff);
    do_rd(`MTS_ADDR_ISR, '1, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    ev(8'h40, 7'h00);
    @(posedge clk);
    {addr, wdata, wr_s} <= {`MTS_ADDR_TSR, 32'h2, 1'b1};
    tx_evt <= 8'h40;
    @(posedge clk);
    wr_s <= 1'b0;
    tx_evt <= '0;
    do_rd(`MTS_ADDR_TSR, 32'h02, 32'h02);
    report_and_stop();
  end
endmodule // mts_tx_status_tb_top

bind mts_tx_status mts_tx_status_chk #(.ADDR_W(ADDR_W)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_TX_EVT(I_TX_EVT), .I_OTHER_EVT(I_OTHER_EVT),
  .I_TX_ACTIVE(I_TX_ACTIVE), .O_TX_CTL(O_TX_CTL), .O_IRQ(O_IRQ));
`default_nettype wire
